// File: rtl/rise_detect.sv
/*
  Zero-to-one change detector for a vector of register bits.
  Assumes the inputs are flops of the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module rise_detect #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;

endmodule : rise_detect
`default_nettype wire

// File: rtl/sar_sequencer.sv
/*
  Successive approximation sequencer: sample phase, then one trial per result
  bit, most significant first. Assumes an analog comparator reporting whether
  the held input is at or above the trial code after the settle time.
*/
`timescale 1ns/100ps
`default_nettype none
module sar_sequencer #(
  parameter int WIDTH = 10,
  parameter int SAMPLE_CYCLES = 8,
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic compAbove,
  output logic sampleEn,
  output logic busy,
  output logic [WIDTH-1:0] trialCode,
  output logic resultStore,
  output logic [WIDTH-1:0] result
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_TRIAL = 2'b10
  } sar_state_t;

  sar_state_t state_q;
  logic [7:0] waitCnt_q;
  logic [WIDTH-1:0] bitMask_q;
  logic [WIDTH-1:0] code_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      waitCnt_q <= 8'h00;
      bitMask_q <= '0;
      code_q <= '0;
      resultStore <= 1'b0;
    end else begin
      resultStore <= 1'b0;
      if (abort) begin
        // Power removed mid-sequence: the result is never stored
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_SAMPLE;
              waitCnt_q <= 8'(SAMPLE_CYCLES - 1);
            end
          end
          ST_SAMPLE: begin
            if (waitCnt_q == 8'h00) begin
              state_q <= ST_TRIAL;
              bitMask_q <= {1'b1, {(WIDTH-1){1'b0}}};
              code_q <= {1'b1, {(WIDTH-1){1'b0}}};
              waitCnt_q <= 8'(SETTLE_CYCLES - 1);
            end else begin
              waitCnt_q <= waitCnt_q - 8'h01;
            end
          end
          ST_TRIAL: begin
            if (waitCnt_q != 8'h00) begin
              waitCnt_q <= waitCnt_q - 8'h01;
            end else begin
              waitCnt_q <= 8'(SETTLE_CYCLES - 1);
              bitMask_q <= bitMask_q >> 1;
              code_q <= (compAbove ? code_q : (code_q & ~bitMask_q)) | (bitMask_q >> 1);
              if (bitMask_q[0]) begin
                state_q <= ST_IDLE;
                resultStore <= 1'b1;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result <= '0;
    end else if (state_q == ST_TRIAL && waitCnt_q == 8'h00 && bitMask_q[0] && !abort) begin
      result <= compAbove ? code_q : (code_q & ~bitMask_q);
    end
  end

  assign trialCode = code_q;
  assign sampleEn = (state_q == ST_SAMPLE);
  assign busy = (state_q != ST_IDLE);

endmodule : sar_sequencer
`default_nettype wire

// File: rtl/touch_adc_control.sv
/*
  Touch panel and converter control registers with the conversion sequencer.
  Assumes the serial host bus decoder outside delivers one-cycle read and write
  strobes with a 4-bit register index and 16-bit data, all on sys_clk.
*/
// Operation
// - Mode 00 interrupt, 01 pressure, 1x position
// - Bits 5-7 ground X+, Y-, Y+
// - Bit 11 enables panel bias circuit
// - Bits 12,13 read inverted X+/X- levels
// - Converter bit 0 enables synchronised mode
// - Converter bit 1 ties reference to bypass
// - Converter bit 5 selects external reference
// - Conversion starts only on bit 7 rising
// - Converter active only while bit 15 set
// - Result in bits 5-14, resets zero
// - Bit 15 reads one once result stored
// - Fixed revision, part and supplier fields
// - Test bits enable audio, telecom test
// - Bits 2-5 select production test mode
// - Bits 0-3 power the plate terminals
// - Bit 4 grounds the X-minus terminal
`timescale 1ns/100ps
`default_nettype none
module touch_adc_control
  import touch_adc_pkg::*;
#(
  parameter logic [5:0] REVISION_CODE = 6'h15, // Arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2a, // Arbitrary value
  parameter logic [3:0] SUPPLIER_CODE = 4'h9, // Arbitrary value
  parameter int SAMPLE_LEN = SAMPLE_CYCLES,
  parameter int SETTLE_LEN = SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  input wire logic testPinHigh,
  // Panel plate drive
  output logic xMinusSupplyEn,
  output logic xPlusSupplyEn,
  output logic yMinusSupplyEn,
  output logic yPlusSupplyEn,
  output logic xMinusGroundEn,
  output logic xPlusGroundEn,
  output logic yMinusGroundEn,
  output logic yPlusGroundEn,
  output logic panelInterruptMode,
  output logic panelPressureMode,
  output logic panelPositionMode,
  output logic panelBiasEn,
  input wire logic xPlusTerminalLevel,
  input wire logic xMinusTerminalLevel,
  // Converter control
  output logic convSyncModeEn,
  output logic intRefToBypass,
  output logic externalReferenceSel,
  output logic converterPowerEn,
  output logic [7:0] inputRouteSel,
  output logic sampleEn,
  output logic [9:0] trialCode,
  input wire logic compAbove,
  output logic conversionBusy,
  // Test modes
  output logic audioAnalogTestEn,
  output logic telecomAnalogTestEn,
  output logic [3:0] productionTestSelect
);

  // ==========================================================================
  // Register storage
  logic [15:0] panelCtrl_q;
  logic [15:0] convCtrl_q;
  logic [5:0] testMode_q;
  logic conversionDone_q;
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;

  logic wrPanel;
  logic wrConv;
  logic wrTest;
  logic startRise;
  logic startConv;
  logic resultStore;
  logic [RESULT_WIDTH-1:0] result;
  logic [1:0] panelMode;
  logic [2:0] inputSel;

  assign wrPanel = regWrEn && (regAddr == PANEL_CONTROL_IDX);
  assign wrConv = regWrEn && (regAddr == CONVERTER_CONTROL_IDX);
  // Writes to the test modes are only honoured with the test pin high, so a
  // stray write in the field cannot alter normal behaviour
  assign wrTest = regWrEn && (regAddr == TEST_MODE_SELECT_IDX) && testPinHigh;

  // ==========================================================================
  // Panel control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      panelCtrl_q <= PANEL_CONTROL_RST;
    end else if (wrPanel) begin
      // Bits 10, 12 and up are not stored; pen bits are live readback
      panelCtrl_q <= {4'h0, regWrData[PANEL_BIAS_BIT], 1'b0, regWrData[9:0]};
    end
  end

  assign xMinusSupplyEn = panelCtrl_q[X_MINUS_SUPPLY_BIT];
  assign xPlusSupplyEn = panelCtrl_q[X_PLUS_SUPPLY_BIT];
  assign yMinusSupplyEn = panelCtrl_q[Y_MINUS_SUPPLY_BIT];
  assign yPlusSupplyEn = panelCtrl_q[Y_PLUS_SUPPLY_BIT];
  assign xMinusGroundEn = panelCtrl_q[X_MINUS_GROUND_BIT];
  assign xPlusGroundEn = panelCtrl_q[X_PLUS_GROUND_BIT];
  assign yMinusGroundEn = panelCtrl_q[Y_MINUS_GROUND_BIT];
  assign yPlusGroundEn = panelCtrl_q[Y_PLUS_GROUND_BIT];
  assign panelBiasEn = panelCtrl_q[PANEL_BIAS_BIT];

  assign panelMode = panelCtrl_q[PANEL_MODE_LSB +: 2];

  always_comb begin
    panelInterruptMode = 1'b0;
    panelPressureMode = 1'b0;
    panelPositionMode = 1'b0;
    case (panelMode)
      PANEL_INTERRUPT: begin
        panelInterruptMode = 1'b1;
      end
      PANEL_PRESSURE: begin
        panelPressureMode = 1'b1;
      end
      default: begin
        // Either value of the low bit gives position mode
        panelPositionMode = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Converter control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      convCtrl_q <= CONVERTER_CONTROL_RST;
    end else if (wrConv) begin
      convCtrl_q <= {regWrData[CONV_POWER_BIT], 7'h00, regWrData[CONV_START_BIT], 1'b0,
                     regWrData[5:0]};
    end
  end

  assign convSyncModeEn = convCtrl_q[CONV_SYNC_BIT];
  assign intRefToBypass = convCtrl_q[INT_REF_BYPASS_BIT];
  assign externalReferenceSel = convCtrl_q[EXT_REF_BIT];
  assign converterPowerEn = convCtrl_q[CONV_POWER_BIT];
  assign inputSel = convCtrl_q[INPUT_SEL_LSB +: 3];

  always_comb begin
    inputRouteSel = 8'h00;
    case (inputSel)
      SEL_X_PLUS: begin
        inputRouteSel = 8'h01;
      end
      SEL_X_MINUS: begin
        inputRouteSel = 8'h02;
      end
      SEL_Y_PLUS: begin
        inputRouteSel = 8'h04;
      end
      SEL_Y_MINUS: begin
        inputRouteSel = 8'h08;
      end
      SEL_AUX0: begin
        inputRouteSel = 8'h10;
      end
      SEL_AUX1: begin
        inputRouteSel = 8'h20;
      end
      SEL_AUX2: begin
        inputRouteSel = 8'h40;
      end
      default: begin
        inputRouteSel = 8'h80;
      end
    endcase
  end

  // ==========================================================================
  // Conversion start and sequencing
  // Only the stored bit's rising edge counts; rewriting one does nothing
  rise_detect #(
    .WIDTH(1)
  ) u_start_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .level(convCtrl_q[CONV_START_BIT]),
    .rise(startRise)
  );

  // A start while powered down is dropped, not remembered
  assign startConv = startRise && converterPowerEn;

  sar_sequencer #(
    .WIDTH(RESULT_WIDTH),
    .SAMPLE_CYCLES(SAMPLE_LEN),
    .SETTLE_CYCLES(SETTLE_LEN)
  ) u_sar (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(startConv),
    .abort(!converterPowerEn),
    .compAbove(compAbove),
    .sampleEn(sampleEn),
    .busy(conversionBusy),
    .trialCode(trialCode),
    .resultStore(resultStore),
    .result(result)
  );

  // Storing wins over a start in the same cycle: the sequencer is already idle
  // then and takes that start, so done reads one while the new conversion runs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversionDone_q <= 1'b0;
    end else if (resultStore) begin
      conversionDone_q <= 1'b1;
    end else if (startConv) begin
      conversionDone_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Test modes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      testMode_q <= TEST_MODE_RST;
    end else if (wrTest) begin
      testMode_q <= regWrData[5:0];
    end
  end

  assign audioAnalogTestEn = testMode_q[AUDIO_TEST_BIT];
  assign telecomAnalogTestEn = testMode_q[TELECOM_TEST_BIT];
  assign productionTestSelect = testMode_q[PROD_TEST_LSB +: 4];

  // ==========================================================================
  // Read path
  always_comb begin
    rdData_d = 16'h0000;
    case (regAddr)
      PANEL_CONTROL_IDX: begin
        rdData_d = panelCtrl_q;
        rdData_d[X_PLUS_PEN_DOWN_BIT] = ~xPlusTerminalLevel;
        rdData_d[X_MINUS_PEN_DOWN_BIT] = ~xMinusTerminalLevel;
      end
      CONVERTER_CONTROL_IDX: begin
        rdData_d = convCtrl_q;
      end
      CONVERTER_RESULT_IDX: begin
        rdData_d[RESULT_LSB +: RESULT_WIDTH] = result;
        rdData_d[DONE_BIT] = conversionDone_q;
      end
      CHIP_IDENTIFICATION_IDX: begin
        rdData_d[REVISION_LSB +: 6] = REVISION_CODE;
        rdData_d[PART_LSB +: 6] = PART_CODE;
        rdData_d[SUPPLIER_LSB +: 4] = SUPPLIER_CODE;
      end
      TEST_MODE_SELECT_IDX: begin
        rdData_d[5:0] = testMode_q;
      end
      default: begin
        rdData_d = 16'h0000;
      end
    endcase
  end

  // Read data holds until the next read so a slow shifter can take it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_q <= 16'h0000;
    end else if (regRdEn) begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

endmodule : touch_adc_control
`default_nettype wire

// File: rtl/touch_adc_pkg.sv
/*
  Shared constants of the touch panel and converter control block: register
  indices, field positions, reset values, input select codes and sequencer timing.
  Assumes the serial host bus logic outside hands over 4-bit register indices.
*/
package touch_adc_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [3:0] PANEL_CONTROL_IDX = 4'h9;
  localparam logic [3:0] CONVERTER_CONTROL_IDX = 4'ha;
  localparam logic [3:0] CONVERTER_RESULT_IDX = 4'hb;
  localparam logic [3:0] CHIP_IDENTIFICATION_IDX = 4'hc;
  localparam logic [3:0] TEST_MODE_SELECT_IDX = 4'hd;

  // ==========================================================================
  // Panel control fields
  localparam int X_MINUS_SUPPLY_BIT = 0;
  localparam int X_PLUS_SUPPLY_BIT = 1;
  localparam int Y_MINUS_SUPPLY_BIT = 2;
  localparam int Y_PLUS_SUPPLY_BIT = 3;
  localparam int X_MINUS_GROUND_BIT = 4;
  localparam int X_PLUS_GROUND_BIT = 5;
  localparam int Y_MINUS_GROUND_BIT = 6;
  localparam int Y_PLUS_GROUND_BIT = 7;
  localparam int PANEL_MODE_LSB = 8;
  localparam int PANEL_BIAS_BIT = 11;
  localparam int X_PLUS_PEN_DOWN_BIT = 12;
  localparam int X_MINUS_PEN_DOWN_BIT = 13;

  // ==========================================================================
  // Converter control and result fields
  localparam int CONV_SYNC_BIT = 0;
  localparam int INT_REF_BYPASS_BIT = 1;
  localparam int INPUT_SEL_LSB = 2;
  localparam int EXT_REF_BIT = 5;
  localparam int CONV_START_BIT = 7;
  localparam int CONV_POWER_BIT = 15;
  localparam int RESULT_LSB = 5;
  localparam int DONE_BIT = 15;

  // ==========================================================================
  // Identification and test mode fields
  localparam int REVISION_LSB = 0;
  localparam int PART_LSB = 6;
  localparam int SUPPLIER_LSB = 12;
  localparam int AUDIO_TEST_BIT = 0;
  localparam int TELECOM_TEST_BIT = 1;
  localparam int PROD_TEST_LSB = 2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] PANEL_CONTROL_RST = 16'h0000;
  localparam logic [15:0] CONVERTER_CONTROL_RST = 16'h0000;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [5:0] TEST_MODE_RST = 6'h00;

  // ==========================================================================
  // Panel modes and converter inputs
  typedef enum logic [1:0] {
    PANEL_INTERRUPT = 2'b00,
    PANEL_PRESSURE = 2'b01,
    PANEL_POSITION = 2'b10
  } panel_mode_t;

  typedef enum logic [2:0] {
    SEL_X_PLUS = 3'b000,
    SEL_X_MINUS = 3'b001,
    SEL_Y_PLUS = 3'b010,
    SEL_Y_MINUS = 3'b011,
    SEL_AUX0 = 3'b100,
    SEL_AUX1 = 3'b101,
    SEL_AUX2 = 3'b110,
    SEL_AUX3 = 3'b111
  } input_sel_t;

  // ==========================================================================
  // Result width and sequencer timing in clock cycles
  localparam int RESULT_WIDTH = 10;
  localparam int SAMPLE_CYCLES = 8;
  localparam int SETTLE_CYCLES = 4;

endpackage : touch_adc_pkg

// File: test/host_model.sv
/*
  System controller model: one-cycle register strobes and the test pin.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] regRdData,
  output logic [3:0] regAddr,
  output logic regWrEn,
  output logic [15:0] regWrData,
  output logic regRdEn,
  output logic testPinHigh
);
  initial begin
    regAddr = 4'h0;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    regRdEn = 1'b0;
    testPinHigh = 1'b0;
  end
  // Start needs a zero then a one written by the caller
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    // Released bus must not keep the old word
    regWrData = ~regWrData;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask : rd
  task automatic pin(input logic v);
    @(negedge sys_clk);
    testPinHigh = v;
  endtask : pin
endmodule : host_model
`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench for touch_adc_control with a host model.
  Assumes a comparator model fed by a static analog level.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
  samplesChecked++; \
  if ((g) !== (e)) begin \
    $display("[FAIL] %s expected %h seen %h", n, e, g); \
    failures++; \
  end \
end
module tb;
  import touch_adc_pkg::*;
  localparam logic [5:0] REV = 6'h2d; // Arbitrary value
  localparam logic [5:0] PART = 6'h13; // Arbitrary value
  localparam logic [3:0] SUP = 4'h6; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic xPlusTerminalLevel = 1'b1;
  logic xMinusTerminalLevel = 1'b1;
  logic compAbove = 1'b0;
  logic [9:0] analogIn = 10'h000;
  logic [3:0] regAddr;
  logic regWrEn, regRdEn, testPinHigh;
  logic [15:0] regWrData, regRdData, rv;
  logic xMinusSupplyEn, xPlusSupplyEn, yMinusSupplyEn, yPlusSupplyEn;
  logic xMinusGroundEn, xPlusGroundEn, yMinusGroundEn, yPlusGroundEn;
  logic panelInterruptMode, panelPressureMode, panelPositionMode, panelBiasEn;
  logic convSyncModeEn, intRefToBypass, externalReferenceSel, converterPowerEn;
  logic sampleEn, conversionBusy, audioAnalogTestEn, telecomAnalogTestEn;
  logic [7:0] inputRouteSel;
  logic [9:0] trialCode;
  logic [3:0] productionTestSelect;
  int failures = 0;
  int samplesChecked = 0;
  int cycles = 0;
  wire [7:0] plates = {yPlusGroundEn, yMinusGroundEn, xPlusGroundEn, xMinusGroundEn,
    yPlusSupplyEn, yMinusSupplyEn, xPlusSupplyEn, xMinusSupplyEn};
  wire [5:0] testBits = {productionTestSelect, telecomAnalogTestEn, audioAnalogTestEn};
  // Short counts keep each conversion near 25 cycles
  touch_adc_control #(.REVISION_CODE(REV), .PART_CODE(PART), .SUPPLIER_CODE(SUP),
    .SAMPLE_LEN(4), .SETTLE_LEN(2)) DUT (.sys_clk, .rst, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .testPinHigh, .xMinusSupplyEn, .xPlusSupplyEn, .yMinusSupplyEn,
    .yPlusSupplyEn, .xMinusGroundEn, .xPlusGroundEn, .yMinusGroundEn, .yPlusGroundEn,
    .panelInterruptMode, .panelPressureMode, .panelPositionMode, .panelBiasEn,
    .xPlusTerminalLevel, .xMinusTerminalLevel, .convSyncModeEn, .intRefToBypass,
    .externalReferenceSel, .converterPowerEn, .inputRouteSel, .sampleEn, .trialCode,
    .compAbove, .conversionBusy, .audioAnalogTestEn, .telecomAnalogTestEn,
    .productionTestSelect);
  host_model hostBus (.sys_clk, .regRdData, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .testPinHigh);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Comparator: held level at or above the trial code
  always @(negedge sys_clk) compAbove <= (trialCode <= analogIn);
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    hostBus.rd(PANEL_CONTROL_IDX, rv);
    `CHK("panel", 16'h0000, rv)
    hostBus.rd(CONVERTER_CONTROL_IDX, rv);
    `CHK("conv", 16'h0000, rv)
    hostBus.rd(CONVERTER_RESULT_IDX, rv);
    `CHK("result", 16'h0000, rv)
    hostBus.rd(CHIP_IDENTIFICATION_IDX, rv);
    `CHK("id", {SUP, PART, REV}, rv)
    hostBus.rd(TEST_MODE_SELECT_IDX, rv);
    `CHK("test", 16'h0000, rv)
    hostBus.rd(4'h3, rv);
    `CHK("unmapped", 16'h0000, rv)
    `CHK("mode", 1'b1, panelInterruptMode)
    `CHK("route", 8'h01, inputRouteSel)
    $display("reset test done");
  endtask : t_reset
  task automatic t_panel();
    xPlusTerminalLevel = 1'b0;
    hostBus.wr(PANEL_CONTROL_IDX, 16'hffff);
    hostBus.rd(PANEL_CONTROL_IDX, rv);
    `CHK("panel rd", 16'h1bff, rv)
    `CHK("plates", 8'hff, plates)
    `CHK("bias", 1'b1, panelBiasEn)
    for (int m = 0; m < 4; m++) begin
      hostBus.wr(PANEL_CONTROL_IDX, 16'(m << 8) | 16'h0055);
      `CHK("modes", {m[1], m == 1, m == 0}, {panelPositionMode, panelPressureMode, panelInterruptMode})
      `CHK("plates", 8'h55, plates)
    end
    `CHK("bias", 1'b0, panelBiasEn)
    xPlusTerminalLevel = 1'b1;
    xMinusTerminalLevel = 1'b0;
    hostBus.rd(PANEL_CONTROL_IDX, rv);
    `CHK("pen", 2'b10, rv[13:12])
    $display("panel test done");
  endtask : t_panel
  task automatic t_route();
    for (int s = 0; s < 8; s++) begin
      hostBus.wr(CONVERTER_CONTROL_IDX, 16'(s << 2) | 16'h0023);
      `CHK("route", 8'(1 << s), inputRouteSel)
    end
    hostBus.rd(CONVERTER_CONTROL_IDX, rv);
    `CHK("conv rd", 16'h003f, rv)
    `CHK("refs", 3'b111, {externalReferenceSel, intRefToBypass, convSyncModeEn})
    `CHK("power", 1'b0, converterPowerEn)
    $display("route test done");
  endtask : t_route
  task automatic waitIdle();
    int n = 0;
    while (conversionBusy !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("started", 1'b1, conversionBusy)
    while (conversionBusy !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("finished", 1'b0, conversionBusy)
    repeat (2) @(negedge sys_clk);
  endtask : waitIdle
  task automatic t_convert();
    analogIn = 10'h2b5;
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h8000);
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h8080);
    waitIdle();
    hostBus.rd(CONVERTER_RESULT_IDX, rv);
    `CHK("result", {1'b1, 10'h2b5, 5'h00}, rv)
    // A second one without a zero in between must not restart
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h8080);
    repeat (4) @(negedge sys_clk);
    `CHK("no restart", 1'b0, conversionBusy)
    analogIn = 10'h1c3;
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h8000);
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h8080);
    hostBus.rd(CONVERTER_RESULT_IDX, rv);
    `CHK("done low", 1'b0, rv[15])
    `CHK("busy", 1'b1, conversionBusy)
    `CHK("sampling", 1'b1, sampleEn)
    hostBus.wr(CONVERTER_CONTROL_IDX, 16'h0080);
    repeat (3) @(negedge sys_clk);
    `CHK("abort", 1'b0, conversionBusy)
    hostBus.rd(CONVERTER_RESULT_IDX, rv);
    `CHK("kept", {1'b0, 10'h2b5, 5'h00}, rv)
    $display("convert test done");
  endtask : t_convert
  task automatic t_test();
    hostBus.pin(1'b1);
    hostBus.wr(TEST_MODE_SELECT_IDX, 16'h003f);
    `CHK("test on", 6'h3f, testBits)
    hostBus.pin(1'b0);
    hostBus.wr(TEST_MODE_SELECT_IDX, 16'h0000);
    `CHK("gated", 6'h3f, testBits)
    hostBus.rd(TEST_MODE_SELECT_IDX, rv);
    `CHK("test rd", 16'h003f, rv)
    hostBus.wr(CONVERTER_RESULT_IDX, 16'hffff);
    hostBus.rd(CONVERTER_RESULT_IDX, rv);
    `CHK("read only", {1'b0, 10'h2b5, 5'h00}, rv)
    $display("test mode test done");
  endtask : t_test
  // ==========================================================================
  // Verdict
  task automatic close_out();
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_panel();
    t_route();
    t_convert();
    t_test();
    close_out();
  end
endmodule : tb
`default_nettype wire

// File: test/touch_adc_monitor.sv
/*
  Port checker for touch_adc_control, bound to every instance.
  Assumes one clock, sys_clk, and a synchronous active-high rst.
*/
`timescale 1ns/100ps
`default_nettype none
module touch_adc_monitor
  import touch_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic testPinHigh,
  input wire logic xPlusTerminalLevel,
  input wire logic xMinusTerminalLevel,
  input wire logic xPlusGroundEn,
  input wire logic yMinusGroundEn,
  input wire logic yPlusGroundEn,
  input wire logic panelPressureMode,
  input wire logic panelPositionMode,
  input wire logic panelBiasEn,
  input wire logic convSyncModeEn,
  input wire logic intRefToBypass,
  input wire logic externalReferenceSel,
  input wire logic converterPowerEn,
  input wire logic [7:0] inputRouteSel,
  input wire logic conversionBusy,
  input wire logic audioAnalogTestEn,
  input wire logic telecomAnalogTestEn,
  input wire logic [3:0] productionTestSelect
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic pw;
  logic cw;
  logic tw;
  logic startWr;
  assign pw = regWrEn && regAddr == PANEL_CONTROL_IDX;
  assign cw = regWrEn && regAddr == CONVERTER_CONTROL_IDX;
  assign tw = regWrEn && regAddr == TEST_MODE_SELECT_IDX;
  assign startWr = cw && regWrData[CONV_START_BIT];
  // ==========================================================================
  // Assertions
  a_mode_decode: assert property (pw |=> panelPositionMode == $past(regWrData[9])
    && panelPressureMode == ($past(regWrData[9:8]) == 2'b01)) else $error("mode decode");
  a_ground_follow: assert property (pw |=>
    {yPlusGroundEn, yMinusGroundEn, xPlusGroundEn} == $past(regWrData[7:5]))
    else $error("ground enables");
  a_bias_follow: assert property (pw |=> panelBiasEn == $past(regWrData[11]))
    else $error("bias enable");
  a_pen_readback: assert property (regRdEn && regAddr == PANEL_CONTROL_IDX |=>
    regRdData[12] == !$past(xPlusTerminalLevel) && regRdData[13] == !$past(xMinusTerminalLevel))
    else $error("pen readback");
  a_conv_fields: assert property (cw |=> {converterPowerEn, externalReferenceSel,
    intRefToBypass, convSyncModeEn} == {$past(regWrData[15]), $past(regWrData[5]),
    $past(regWrData[1]), $past(regWrData[0])}) else $error("converter fields");
  a_route_onehot: assert property (cw |=> inputRouteSel == 8'h01 << $past(regWrData[4:2]))
    else $error("input route");
  a_start_cause: assert property ($rose(conversionBusy) |->
    $past(startWr, 1) || $past(startWr, 2)) else $error("start without write");
  a_abort_stop: assert property ($fell(converterPowerEn) |-> ##[0:2] !conversionBusy)
    else $error("busy after power down");
  a_test_gate: assert property (tw && !testPinHigh |=>
    $stable({productionTestSelect, telecomAnalogTestEn, audioAnalogTestEn}))
    else $error("test write not gated");
  a_test_write: assert property (tw && testPinHigh |=>
    {productionTestSelect, telecomAnalogTestEn, audioAnalogTestEn} == $past(regWrData[5:0]))
    else $error("test write");
  c_conv_end: cover property ($fell(conversionBusy));
  c_test_on: cover property (tw && testPinHigh);
  c_result_rd: cover property (regRdEn && regAddr == CONVERTER_RESULT_IDX);
endmodule : touch_adc_monitor
bind touch_adc_control touch_adc_monitor mon (.sys_clk, .rst, .regAddr, .regWrEn, .regWrData,
  .regRdEn, .regRdData, .testPinHigh, .xPlusTerminalLevel, .xMinusTerminalLevel,
  .xPlusGroundEn, .yMinusGroundEn, .yPlusGroundEn, .panelPressureMode, .panelPositionMode,
  .panelBiasEn, .convSyncModeEn, .intRefToBypass, .externalReferenceSel, .converterPowerEn,
  .inputRouteSel, .conversionBusy, .audioAnalogTestEn, .telecomAnalogTestEn,
  .productionTestSelect);
`default_nettype wire
